// [core/lpsc_consts.svh]
// Constants of the line printer status and control block.
// Assumes inclusion by core modules only; definitions only.
`ifndef LPSC_CONSTS_SVH
`define LPSC_CONSTS_SVH
`define LPSC_ST_READY 0
`define LPSC_ST_BUSY 1
`define LPSC_ST_INT 2
`define LPSC_ST_DATA 3
`define LPSC_ST_EOP 4
`define LPSC_ST_ALARM 5
`define LPSC_ST_ERROR 6
`define LPSC_ST_PROT 7
`define LPSC_ST_IMAGE 8
`define LPSC_FN_CLEAR 0
`define LPSC_FN_CLRINT 1
`define LPSC_FN_RQDATA 2
`define LPSC_FN_RQEOP 3
`define LPSC_FN_RQALARM 4
`define LPSC_FN_PRINT 5
`define LPSC_CC_VFC 6
`define LPSC_EQ_LSB 7
`define LPSC_EQ_MSB 10
`define LPSC_W_LSB 11
`define LPSC_W_MSB 15
`define LPSC_IMAGE_CHARS 9'h0120
`define LPSC_FIFO_DEPTH 4
`define LPSC_DATA_W 8
`endif

// [core/lpsc_fifo.sv]
// Small FIFO for characters bound for the printer.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lpsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [core/lpsc_pkg.sv]
// Types of the line printer status and control block.
// Assumes lpsc_consts.svh for the character width.
`include "lpsc_consts.svh"
package lpsc_pkg;
  typedef logic [15:0] lpsc_word_t;
  typedef logic [`LPSC_DATA_W-1:0] lpsc_char_t;
  typedef enum logic [3:0] {
    LPSC_SP_NONE = 4'h0,
    LPSC_SP_ONE = 4'h1,
    LPSC_SP_TWO = 4'h2,
    LPSC_SP_THREE = 4'h3
  } lpsc_space_t;
  typedef enum logic [3:0] {
    LPSC_S_IDLE = 4'b0001,
    LPSC_S_STROBE = 4'b0010,
    LPSC_S_WAIT_ACK = 4'b0100,
    LPSC_S_WAIT_REQ = 4'b1000
  } lpsc_state_t;
endpackage

// [core/lpsc_stream_if.sv]
// Valid/ready character stream between the controller and its FIFO.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface lpsc_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [core/lpsc_top.sv]
// Line printer controller: status word, director functions, data path.
// Assumes host channel signals synchronous to clk; one request per timing pulse.
`timescale 1ns/1ps
`default_nettype none
`include "lpsc_consts.svh"
module lpsc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic channel_timing_pulse,
  input wire logic host_read,
  input wire logic host_write,
  input wire logic program_protect,
  input wire lpsc_pkg::lpsc_word_t host_q,
  input wire lpsc_pkg::lpsc_word_t host_a,
  input wire logic protect_jumper,
  input wire logic [3:0] equip_jumper,
  input wire logic lp_ready,
  input wire logic lp_line_ready,
  input wire logic lp_char_request,
  input wire logic lp_parity_error,
  input wire logic lp_sync_compare_error,
  input wire logic lp_alarm,
  input wire logic lp_image_mode,
  input wire logic lp_paper_moving,
  input wire logic lp_wide_model,
  output logic host_reply,
  output logic host_reject,
  output lpsc_pkg::lpsc_word_t host_data_out,
  output logic host_data_oe,
  output logic [7:0] lp_data,
  output logic lp_parity,
  output logic lp_control_bit,
  output logic lp_strobe,
  output logic lp_buffer_clear,
  output logic irq_eop,
  output logic irq_common,
  output logic irq_data,
  output logic irq_alarm,
  output logic [3:0] cc_spacing,
  output logic [3:0] cc_channel,
  output logic cc_vfc
);
  import lpsc_pkg::*;

  function automatic logic is_control_transfer(input logic first, input logic wr);
    return first && wr;
  endfunction

  logic equipment_selected_flop;
  logic sel_next;
  logic prot_ok;
  logic fcn;
  logic wdta;
  logic status_rd;
  logic illegal;
  logic data_reg;
  logic eop_reg;
  logic alarm_reg;
  logic error_reg;
  logic hard_err_reg;
  logic busy_reg;
  logic ccbusy_reg;
  logic cc_sent_reg;
  logic first_char_reg;
  logic rq_data_reg;
  logic rq_eop_reg;
  logic rq_alarm_reg;
  logic line_rdy_d_reg;
  logic halt_reg;
  logic [8:0] image_cnt_reg;
  logic wd_ok;
  logic fn_ok;
  logic clear_controller_directive;
  logic clri;
  logic print_go;
  logic xfer;
  logic do_wd;
  logic line_rise;
  logic int_any;
  logic busy_any;
  lpsc_word_t status;
  lpsc_state_t st_reg;
  logic [1:0] stb_cnt_reg;
  logic fifo_out_valid;
  logic fifo_in_ready;
  logic [8:0] fifo_out;
  logic fifo_pop;

  // Protect jumper absent means protected
  assign prot_ok = protect_jumper || program_protect;
  assign sel_next = (host_q[`LPSC_EQ_MSB:`LPSC_EQ_LSB] == equip_jumper)
    && (host_q[`LPSC_W_MSB:`LPSC_W_LSB] == 5'h0_0) && (host_read || host_write);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      equipment_selected_flop <= 1'b0;
    end else begin
      equipment_selected_flop <= channel_timing_pulse && sel_next;
    end
  end

  assign fcn = equipment_selected_flop && host_write && host_q[0];
  assign wdta = equipment_selected_flop && host_write && !host_q[0];
  assign status_rd = equipment_selected_flop && host_read && host_q[0];
  assign illegal = equipment_selected_flop && host_read && !host_q[0];
  // Any busy cause refuses data writes and print, not only the print cycle
  assign busy_any = busy_reg || ccbusy_reg || hard_err_reg;
  assign wd_ok = prot_ok && data_reg && lp_ready && !busy_any && lp_line_ready
    && !halt_reg && fifo_in_ready;
  assign fn_ok = prot_ok && (!host_a[`LPSC_FN_PRINT] || (lp_ready && !busy_any && data_reg));
  assign do_wd = wdta && wd_ok;
  assign clear_controller_directive = fcn && fn_ok && host_a[`LPSC_FN_CLEAR];
  assign clri = fcn && fn_ok && (host_a[`LPSC_FN_CLRINT] || host_a[`LPSC_FN_CLEAR]);
  assign print_go = fcn && fn_ok && host_a[`LPSC_FN_PRINT];
  assign xfer = do_wd || print_go;
  assign line_rise = lp_line_ready && !line_rdy_d_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      host_reply <= 1'b0;
      host_reject <= 1'b0;
      host_data_out <= '0;
      host_data_oe <= 1'b0;
    end else begin
      host_reply <= status_rd || do_wd || (fcn && fn_ok);
      host_reject <= illegal || (wdta && !wd_ok) || (fcn && !fn_ok);
      host_data_out <= status_rd ? status : '0;
      host_data_oe <= status_rd;
    end
  end

  // Data flag follows character request; a transfer or print drops it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_reg <= 1'b0;
      // Idle level of line ready is high; avoids a false edge after reset
      line_rdy_d_reg <= 1'b1;
    end else begin
      line_rdy_d_reg <= lp_line_ready;
      if (clear_controller_directive || xfer) begin
        data_reg <= 1'b0;
      end else if (lp_char_request && st_reg == LPSC_S_IDLE && !fifo_out_valid) begin
        data_reg <= 1'b1;
      end
    end
  end

  // Line-ready edge beats a same-cycle clear so the event is kept
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      eop_reg <= 1'b0;
    end else if (line_rise) begin
      eop_reg <= 1'b1;
    end else if (clear_controller_directive || xfer) begin
      eop_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alarm_reg <= 1'b0;
    end else if (lp_alarm || lp_parity_error || lp_sync_compare_error) begin
      alarm_reg <= 1'b1;
    end else if (clear_controller_directive || xfer) begin
      alarm_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      error_reg <= 1'b0;
      hard_err_reg <= 1'b0;
    end else begin
      if (lp_parity_error) begin
        error_reg <= 1'b1;
      end else if (clear_controller_directive || xfer) begin
        error_reg <= 1'b0;
      end
      if (lp_wide_model && lp_sync_compare_error) begin
        hard_err_reg <= 1'b1;
      end else if (clear_controller_directive) begin
        hard_err_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      halt_reg <= 1'b0;
      image_cnt_reg <= '0;
    end else begin
      if (lp_wide_model && lp_image_mode && lp_parity_error) begin
        halt_reg <= 1'b1;
      end else if (clear_controller_directive) begin
        halt_reg <= 1'b0;
      end
      if (clear_controller_directive || !lp_image_mode) begin
        image_cnt_reg <= '0;
      end else if (do_wd && image_cnt_reg != `LPSC_IMAGE_CHARS) begin
        image_cnt_reg <= image_cnt_reg + 9'h001;
      end
    end
  end

  // Busy runs from print accept until line ready returns
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
    end else if (print_go) begin
      busy_reg <= 1'b1;
    end else if (clear_controller_directive || line_rise) begin
      busy_reg <= 1'b0;
    end
  end

  // Control character tracking: first write after print is control
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      first_char_reg <= 1'b1;
      cc_sent_reg <= 1'b0;
      ccbusy_reg <= 1'b0;
    end else begin
      if (print_go || clear_controller_directive) begin
        first_char_reg <= 1'b1;
      end else if (do_wd) begin
        first_char_reg <= 1'b0;
      end
      // Printer moves paper without busy; only a following clear exposes it
      cc_sent_reg <= is_control_transfer(first_char_reg, do_wd) ? 1'b1
        : ((fcn || do_wd) ? 1'b0 : cc_sent_reg);
      if (clear_controller_directive && cc_sent_reg && lp_paper_moving) begin
        ccbusy_reg <= 1'b1;
      end else if (!lp_paper_moving) begin
        ccbusy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cc_spacing <= LPSC_SP_NONE;
      cc_channel <= 4'h0;
      cc_vfc <= 1'b0;
    end else if (is_control_transfer(first_char_reg, do_wd)) begin
      if (host_a[`LPSC_CC_VFC] && host_a[3:2] != 2'b11) begin
        cc_vfc <= 1'b1;
        cc_channel <= host_a[3:0];
        cc_spacing <= LPSC_SP_NONE;
      end else begin
        cc_vfc <= 1'b0;
        cc_channel <= 4'h0;
        cc_spacing <= lpsc_space_t'({2'b00, host_a[1:0]});
      end
    end
  end

  // Requests set on the accepted write; for all three, set beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rq_data_reg <= 1'b0;
      rq_eop_reg <= 1'b0;
      rq_alarm_reg <= 1'b0;
    end else begin
      if (fcn && fn_ok && host_a[`LPSC_FN_RQDATA]) begin
        rq_data_reg <= 1'b1;
      end else if (clri) begin
        rq_data_reg <= 1'b0;
      end
      if (fcn && fn_ok && host_a[`LPSC_FN_RQEOP]) begin
        rq_eop_reg <= 1'b1;
      end else if (clri) begin
        rq_eop_reg <= 1'b0;
      end
      if (fcn && fn_ok && host_a[`LPSC_FN_RQALARM]) begin
        rq_alarm_reg <= 1'b1;
      end else if (clri) begin
        rq_alarm_reg <= 1'b0;
      end
    end
  end

  assign int_any = (rq_data_reg && data_reg) || (rq_eop_reg && eop_reg)
    || (rq_alarm_reg && alarm_reg);

  always_comb begin
    status = '0;
    status[`LPSC_ST_READY] = lp_ready;
    status[`LPSC_ST_BUSY] = busy_any;
    status[`LPSC_ST_INT] = int_any;
    status[`LPSC_ST_DATA] = data_reg;
    status[`LPSC_ST_EOP] = eop_reg;
    status[`LPSC_ST_ALARM] = alarm_reg;
    status[`LPSC_ST_ERROR] = error_reg || hard_err_reg;
    status[`LPSC_ST_PROT] = !protect_jumper;
    status[`LPSC_ST_IMAGE] = lp_wide_model && lp_image_mode
      && image_cnt_reg != `LPSC_IMAGE_CHARS;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_eop <= 1'b0;
      irq_data <= 1'b0;
      irq_alarm <= 1'b0;
      irq_common <= 1'b0;
      lp_buffer_clear <= 1'b0;
    end else begin
      irq_eop <= rq_eop_reg && eop_reg;
      irq_data <= rq_data_reg && data_reg;
      irq_alarm <= rq_alarm_reg && alarm_reg;
      irq_common <= int_any;
      lp_buffer_clear <= clear_controller_directive;
    end
  end

  lpsc_stream_if wr_s ();
  assign wr_s.valid = xfer;
  assign wr_s.data = host_a[7:0];
  assign wr_s.ready = fifo_in_ready;

  // Print rides the same queue as a tagged entry so order is preserved
  lpsc_fifo #(.WIDTH(9), .DEPTH(`LPSC_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(wr_s.valid),
    .in_data({print_go, print_go ? 8'h00 : wr_s.data}),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out),
    .out_ready(fifo_pop)
  );

  assign fifo_pop = (st_reg == LPSC_S_IDLE) && fifo_out_valid && lp_char_request;

  // Strobe sequencer; printer back-pressure via character request stalls the FIFO
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= LPSC_S_IDLE;
      stb_cnt_reg <= '0;
      lp_data <= '0;
      lp_parity <= 1'b0;
      lp_control_bit <= 1'b0;
      lp_strobe <= 1'b0;
    end else begin
      unique case (st_reg)
        LPSC_S_IDLE: begin
          if (fifo_pop) begin
            lp_data <= fifo_out[7:0];
            lp_parity <= ~^fifo_out[7:0];
            lp_control_bit <= fifo_out[8];
            stb_cnt_reg <= 2'h3;
            st_reg <= LPSC_S_STROBE;
          end
        end
        LPSC_S_STROBE: begin
          if (stb_cnt_reg == 2'h0) begin
            lp_strobe <= 1'b1;
            st_reg <= LPSC_S_WAIT_ACK;
          end else begin
            stb_cnt_reg <= stb_cnt_reg - 2'h1;
          end
        end
        LPSC_S_WAIT_ACK: begin
          if (!lp_char_request) begin
            lp_strobe <= 1'b0;
            st_reg <= LPSC_S_WAIT_REQ;
          end
        end
        LPSC_S_WAIT_REQ: begin
          if (lp_char_request) begin
            lp_control_bit <= 1'b0;
            st_reg <= LPSC_S_IDLE;
          end
        end
        default: begin
          st_reg <= LPSC_S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [tb/lpsc_assertions.sv]
// Host port checker for the printer controller.
// Assumes binding onto lpsc_top, one clock.
`timescale 1ns/1ps
`default_nettype none
module lpsc_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic channel_timing_pulse,
  input wire logic host_read,
  input wire logic host_write,
  input wire logic program_protect,
  input wire lpsc_pkg::lpsc_word_t host_q,
  input wire logic protect_jumper,
  input wire logic [3:0] equip_jumper,
  input wire logic host_reply,
  input wire logic host_reject,
  input wire lpsc_pkg::lpsc_word_t host_data_out,
  input wire logic host_data_oe
);
  import lpsc_pkg::*;
  wire logic req = channel_timing_pulse && (host_read || host_write);
  wire logic hit = req && host_q[15:11] == 5'h00 && host_q[10:7] == equip_jumper;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_hi; host_data_oe |-> host_data_out[15:9] == 7'h00; endproperty
  a_hi: assert property (p_hi) else $error("unused status bits set");
  property p_idle; !host_data_oe |-> host_data_out == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("data lines not zero");
  property p_ans; hit |-> ##2 (host_reply ^ host_reject); endproperty
  a_ans: assert property (p_ans) else $error("no single answer");
  property p_foreign; req && !hit |-> ##2 !(host_reply || host_reject); endproperty
  a_foreign: assert property (p_foreign) else $error("foreign request answered");
  property p_status;
    hit && host_read && host_q[0] |-> ##2 host_reply && host_data_oe;
  endproperty
  a_status: assert property (p_status) else $error("status read not answered");
  property p_illegal;
    hit && host_read && !host_q[0] |-> ##2 host_reject && !host_data_oe;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal read not rejected");
  property p_guard;
    hit && host_write && !protect_jumper && !program_protect |-> ##2 host_reject;
  endproperty
  a_guard: assert property (p_guard) else $error("unprotected write taken");
  property p_prot; host_data_oe |-> host_data_out[7] == !$past(protect_jumper, 1); endproperty
  a_prot: assert property (p_prot) else $error("protect bit wrong");
  property p_data; host_data_oe |-> host_reply && !$past(host_data_oe); endproperty
  a_data: assert property (p_data) else $error("status data without reply");
endmodule
bind lpsc_top lpsc_checker chk_i (
  .clk(clk), .reset_n(reset_n), .channel_timing_pulse(channel_timing_pulse),
  .host_read(host_read), .host_write(host_write), .program_protect(program_protect),
  .host_q(host_q), .protect_jumper(protect_jumper), .equip_jumper(equip_jumper),
  .host_reply(host_reply), .host_reject(host_reject), .host_data_out(host_data_out),
  .host_data_oe(host_data_oe)
);
`default_nettype wire

// [tb/lpsc_printer_model.sv]
// Behavioural line printer on the far side of the controller.
// Assumes the strobe is held until character request drops.
`timescale 1ns/1ps
`default_nettype none
module lpsc_printer_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic lp_strobe,
  input wire logic lp_control_bit,
  input wire logic [3:0] slow,
  output logic lp_line_ready,
  output logic lp_char_request,
  output logic lp_paper_moving
);
  int hold;
  logic first;
  always @(posedge clk) begin
    if (!reset_n) begin
      lp_line_ready <= 1'b1;
      lp_char_request <= 1'b1;
      lp_paper_moving <= 1'b0;
      first <= 1'b1;
      hold <= 0;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else if (lp_strobe && lp_char_request) begin
      lp_char_request <= 1'b0;
      hold <= lp_control_bit ? 20 + slow : 2 + slow;
      if (lp_control_bit) begin
        // Print cycle, next character is control again
        lp_line_ready <= 1'b0;
        first <= 1'b1;
      end else if (first) begin
        // Paper moves at once, busy left alone
        lp_paper_moving <= 1'b1;
        first <= 1'b0;
      end
    end else if (!lp_strobe && !lp_char_request) begin
      lp_char_request <= 1'b1;
      lp_line_ready <= 1'b1;
      lp_paper_moving <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the printer controller.
// Assumes lpsc_top, its checker and the printer model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lpsc_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, pulse = 1'b0, rd = 1'b0, wr = 1'b0, pp = 1'b0;
  logic pj = 1'b1, rdy = 1'b1, perr = 1'b0, serr = 1'b0, alarm = 1'b0, img = 1'b0;
  logic wide = 1'b0, stb_d = 1'b0, ev, vfc, rp, rj, bc;
  logic line_rdy, creq, moving, reply, reject, oe, par, ctl, stb, bclr, ie, ic, id, ia;
  logic [3:0] eq = 4'h0, slow = 4'h2, sp, ch;
  logic [7:0] lfsr = 8'h50, lpd, c;
  logic [7:0] codes[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h40, 8'h41, 8'h4b, 8'h4c, 8'h4f};
  logic [7:0] sent[$], seen[$];
  lpsc_word_t q = 16'h0000, a = 16'h0000, dout, sw;
  int fails = 0, samples_checked = 0, cyc = 0;
  lpsc_top dut (.clk(clk), .reset_n(reset_n), .channel_timing_pulse(pulse),
    .host_read(rd), .host_write(wr), .program_protect(pp), .host_q(q), .host_a(a),
    .protect_jumper(pj), .equip_jumper(eq), .lp_ready(rdy), .lp_line_ready(line_rdy),
    .lp_char_request(creq), .lp_parity_error(perr), .lp_sync_compare_error(serr),
    .lp_alarm(alarm), .lp_image_mode(img), .lp_paper_moving(moving), .lp_wide_model(wide),
    .host_reply(reply), .host_reject(reject), .host_data_out(dout), .host_data_oe(oe),
    .lp_data(lpd), .lp_parity(par), .lp_control_bit(ctl), .lp_strobe(stb),
    .lp_buffer_clear(bclr), .irq_eop(ie), .irq_common(ic), .irq_data(id), .irq_alarm(ia),
    .cc_spacing(sp), .cc_channel(ch), .cc_vfc(vfc));
  lpsc_printer_model printer (.clk(clk), .reset_n(reset_n), .lp_strobe(stb),
    .lp_control_bit(ctl), .slow(slow), .lp_line_ready(line_rdy), .lp_char_request(creq),
    .lp_paper_moving(moving));
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic lpsc_word_t qw(input logic b);
    return {5'h00, eq, 6'h00, b};
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Read, write and words stand through the select cycle; answer read after it
  task automatic req(input logic r, input lpsc_word_t qq, input lpsc_word_t aa);
    @(negedge clk);
    pulse = 1'b1;
    rd = r;
    wr = !r;
    q = qq;
    a = aa;
    @(negedge clk);
    pulse = 1'b0;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
    rp = reply;
    rj = reject;
    sw = dout;
    bc = bclr;
  endtask
  task automatic st();
    req(1'b1, qw(1'b1), 16'h0000);
  endtask
  task automatic fn(input lpsc_word_t aa);
    req(1'b0, qw(1'b1), aa);
  endtask
  task automatic wd(input logic [7:0] d, input logic e);
    req(1'b0, qw(1'b0), {8'h00, d});
    chk("data reply", rp, e);
    if (e) sent.push_back(d);
  endtask
  task automatic wait_st(input int b, input logic v);
    for (int k = 0; k < 100; k++) begin
      st();
      if (sw[b] === v) return;
    end
    chk("status wait", sw[b], v);
  endtask
  always @(negedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
    stb_d <= stb;
    if (stb && !stb_d && !ctl) begin
      seen.push_back(lpd);
      chk("odd parity", ^{lpd, par}, 1'b1);
    end
  end
  initial begin
    lfsr = nxt(lfsr);
    eq = lfsr[3:0];
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      pj = i[1];
      pp = i[0];
      st();
      chk("status reply", rp, 1'b1);
      chk("protect bit", sw[7], !pj);
      chk("unused bits", sw[15:9], 7'h00);
      fn(16'h0000);
      chk("director reject", rj, !pj && !pp);
    end
    @(negedge clk);
    pj = 1'b1;
    req(1'b1, qw(1'b1) ^ 16'h0080, 16'h0000);
    chk("foreign code", rp | rj, 1'b0);
    req(1'b0, qw(1'b1) | 16'h0800, 16'h0000);
    chk("w bits", rp | rj, 1'b0);
    req(1'b1, qw(1'b0), 16'h0000);
    chk("illegal read", rj, 1'b1);
    @(negedge clk);
    rdy = 1'b0;
    st();
    chk("not ready", sw[0], 1'b0);
    wd(8'h01, 1'b0);
    @(negedge clk);
    rdy = 1'b1;
    $display("host port test done");
    fn(16'h0008);
    foreach (codes[i]) begin
      c = codes[i];
      wait_st(3, 1'b1);
      wd(c, 1'b1);
      wd(8'h20, 1'b0);
      wait_st(3, 1'b1);
      ev = c[6] && c[3:2] != 2'b11;
      chk("vfc", vfc, ev);
      if (ev) chk("channel", ch, c[3:0]);
      else chk("spacing", sp, c[1:0]);
      lfsr = nxt(lfsr);
      wd(lfsr & 8'h3f, 1'b1);
      st();
      chk("eop cleared", sw[4], 1'b0);
      wait_st(3, 1'b1);
      fn(16'h0020);
      st();
      chk("busy", sw[1], 1'b1);
      wait_st(1, 1'b0);
      chk("eop set", sw[4], 1'b1);
      chk("eop irq", ie, 1'b1);
      chk("int bit", sw[2], 1'b1);
    end
    $display("print test done");
    @(negedge clk);
    slow = 4'hf;
    wait_st(3, 1'b1);
    wd(8'h01, 1'b1);
    for (int k = 0; k < 50 && !moving; k++) @(negedge clk);
    fn(16'h0001);
    st();
    chk("busy after clear", sw[1], 1'b1);
    wait_st(1, 1'b0);
    @(negedge clk);
    alarm = 1'b1;
    fn(16'h0010);
    st();
    chk("alarm", sw[5], 1'b1);
    chk("alarm int", sw[2], 1'b1);
    chk("alarm irq", ia, 1'b1);
    chk("common irq", ic, 1'b1);
    fn(16'h0001);
    st();
    chk("alarm held", sw[5], 1'b1);
    @(negedge clk);
    alarm = 1'b0;
    fn(16'h0001);
    st();
    chk("alarm gone", sw[5], 1'b0);
    chk("int cleared", sw[2], 1'b0);
    wait_st(3, 1'b1);
    fn(16'h0004);
    st();
    chk("data irq", id, 1'b1);
    fn(16'h0002);
    st();
    chk("data irq off", id, 1'b0);
    @(negedge clk);
    perr = 1'b1;
    @(negedge clk);
    perr = 1'b0;
    st();
    chk("parity err", sw[6], 1'b1);
    chk("still ready", sw[0], 1'b1);
    fn(16'h0001);
    st();
    chk("parity cleared", sw[6], 1'b0);
    @(negedge clk);
    wide = 1'b1;
    serr = 1'b1;
    @(negedge clk);
    serr = 1'b0;
    st();
    chk("sync err", sw[6], 1'b1);
    chk("sync busy", sw[1], 1'b1);
    wd(8'h01, 1'b0);
    fn(16'h0001);
    chk("buffer clear", bc, 1'b1);
    st();
    chk("sync cleared", sw[6], 1'b0);
    @(negedge clk);
    img = 1'b1;
    st();
    chk("image", sw[8], 1'b1);
    $display("status test done");
    chk("char count", 16'(seen.size()), 16'(sent.size()));
    foreach (sent[i]) chk("char", seen[i], sent[i]);
    wrap_up();
  end
endmodule
`default_nettype wire
